// file: rtl/pafc_checker.v
// process-data access fault checker: checks each entry, latches one fault
// ============================================================
`timescale 1ns/10ps
`include "pafc_consts.vh"

module pafc_checker
(
	// clock and reset
	input  wire                      core_clk,
	input  wire                      reset_n,
	// process-data entry from the message decoder
	input  wire                      pdo_valid,
	input  wire [`PAFC_IDX_W-1:0]    pdo_index,
	input  wire [`PAFC_SUB_W-1:0]    pdo_subidx,
	input  wire [`PAFC_LEN_W-1:0]    pdo_len,
	input  wire [`PAFC_DATA_W-1:0]   pdo_data,
	// network management and drive state
	input  wire                      nmt_reset_node,
	input  wire                      drive_enabled_pin,
	// write to the dictionary
	output reg                       obj_wr_q,
	output reg  [`PAFC_IDX_W-1:0]    obj_wr_index_q,
	output reg  [`PAFC_SUB_W-1:0]    obj_wr_subidx_q,
	output reg  [`PAFC_DATA_W-1:0]   obj_wr_data_q,
	// fault report
	output reg                       fault_active_q,
	output reg  [`PAFC_CODE_W-1:0]   fault_code_q,
	output reg                       fault_event_q
);

	// ============================================================
	// drive-enable synchroniser
	reg enable_meta_q;
	reg enable_sync_q;

	always @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			enable_meta_q <= 1'b0;
			enable_sync_q <= 1'b0;
		end
		else
		begin
			enable_meta_q <= drive_enabled_pin;
			enable_sync_q <= enable_meta_q;
		end
	end

	// ============================================================
	// dictionary lookup
	wire                     idx_hit;
	wire                     sub_hit;
	wire [`PAFC_LEN_W-1:0]   obj_len;
	wire [`PAFC_DATA_W-1:0]  obj_min;
	wire [`PAFC_DATA_W-1:0]  obj_max;
	wire [`PAFC_ATTR_W-1:0]  obj_attr;

	pafc_dict u_dict
	(
		.q_index  (pdo_index),
		.q_subidx (pdo_subidx),
		.idx_hit  (idx_hit),
		.sub_hit  (sub_hit),
		.obj_len  (obj_len),
		.obj_min  (obj_min),
		.obj_max  (obj_max),
		.obj_attr (obj_attr)
	);

	// ============================================================
	// range compare, signed or unsigned by attribute
	function in_range;
		input [`PAFC_DATA_W-1:0] v;
		input [`PAFC_DATA_W-1:0] lo;
		input [`PAFC_DATA_W-1:0] hi;
		input                    sgn;
		begin
			if (sgn)
				in_range = ($signed(v) >= $signed(lo)) && ($signed(v) <= $signed(hi));
			else
				in_range = (v >= lo) && (v <= hi);
		end
	endfunction

	// ============================================================
	// attribute bits of the addressed object
	wire attr_ro     = obj_attr[`PAFC_ATTR_RO];
	wire attr_map    = obj_attr[`PAFC_ATTR_MAP];
	wire attr_lock   = obj_attr[`PAFC_ATTR_SRVLOCK];
	wire attr_signed = obj_attr[`PAFC_ATTR_SIGNED];

	// ============================================================
	// one flag per check
	// unknown index
	wire fail_index  = !idx_hit;
	wire fail_subidx = !sub_hit;
	wire fail_size   = (pdo_len != obj_len);
	wire fail_range  = !in_range(pdo_data, obj_min, obj_max, attr_signed);
	wire fail_rdonly = attr_ro;
	wire fail_nomap  = !attr_map;
	wire fail_srvon  = enable_sync_q && attr_lock;

	// ============================================================
	// prioritised check
	reg [`PAFC_CODE_W-1:0] code_d;

	always @*
	begin
		if (fail_index)
			code_d = `PAFC_CODE_INDEX;
		else if (fail_subidx)
			code_d = `PAFC_CODE_SUBIDX;
		else if (fail_size)
			code_d = `PAFC_CODE_SIZE;
		else if (fail_range)
			code_d = `PAFC_CODE_RANGE;
		else if (fail_rdonly)
			code_d = `PAFC_CODE_RDONLY;
		else if (fail_nomap)
			code_d = `PAFC_CODE_NOMAP;
		else if (fail_srvon)
			code_d = `PAFC_CODE_SRVON;
		else
			code_d = `PAFC_CODE_NONE;
	end

	// ============================================================
	// entry classification
	wire entry_bad = pdo_valid && (code_d != `PAFC_CODE_NONE);
	wire entry_ok  = pdo_valid && (code_d == `PAFC_CODE_NONE);
	wire ctrl_wr   = entry_ok && (pdo_index == `PAFC_CTRLWORD_IDX);
	wire clear_req = nmt_reset_node || ctrl_wr;
	// set wins: a clear in the same cycle lets a new fault latch
	wire fault_set = entry_bad && (!fault_active_q || clear_req);

	// ============================================================
	// new-fault pulse
	always @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			fault_event_q <= 1'b0;
		else
			fault_event_q <= fault_set;
	end

	// ============================================================
	// write strobe, only for entries that pass every check
	always @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			obj_wr_q <= 1'b0;
		else
			obj_wr_q <= entry_ok;
	end

	// ============================================================
	// written fields, held between writes
	always @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			obj_wr_index_q  <= {`PAFC_IDX_W{1'b0}};
			obj_wr_subidx_q <= {`PAFC_SUB_W{1'b0}};
			obj_wr_data_q   <= {`PAFC_DATA_W{1'b0}};
		end
		else if (entry_ok)
		begin
			obj_wr_index_q  <= pdo_index;
			obj_wr_subidx_q <= pdo_subidx;
			obj_wr_data_q   <= pdo_data;
		end
	end

	// ============================================================
	// fault latch
	always @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			fault_active_q <= 1'b0;
		else if (fault_set)
			fault_active_q <= 1'b1;
		else if (clear_req)
			fault_active_q <= 1'b0;
	end

	// ============================================================
	// latched fault code
	always @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			fault_code_q <= `PAFC_CODE_NONE;
		else if (fault_set)
			fault_code_q <= code_d;
		else if (clear_req)
			fault_code_q <= `PAFC_CODE_NONE;
	end

endmodule // pafc_checker

// file: pkg/pafc_consts.vh
// constants for the process-data access fault checker
`ifndef PAFC_CONSTS_VH
`define PAFC_CONSTS_VH

// ============================================================
// fault codes as reported, in priority order
`define PAFC_CODE_W        8
`define PAFC_CODE_NONE     8'h00
`define PAFC_CODE_INDEX    8'h79
`define PAFC_CODE_SUBIDX   8'h7a
`define PAFC_CODE_SIZE     8'h7b
`define PAFC_CODE_RANGE    8'h7c
`define PAFC_CODE_RDONLY   8'h7d
`define PAFC_CODE_NOMAP    8'h7e
`define PAFC_CODE_SRVON    8'h7f

// ============================================================
// message and dictionary widths
`define PAFC_IDX_W         16
`define PAFC_SUB_W         8
`define PAFC_LEN_W         4
`define PAFC_DATA_W        32
`define PAFC_CTRLWORD_IDX  16'h6040

// ============================================================
// dictionary entry attribute bits
`define PAFC_ATTR_W        4
`define PAFC_ATTR_RO       0
`define PAFC_ATTR_MAP      1
`define PAFC_ATTR_SRVLOCK  2
`define PAFC_ATTR_SIGNED   3

// ============================================================
// dictionary table
`define PAFC_N_OBJ         8
`define PAFC_OBJ_SEL_W     3

// ============================================================
// dictionary entry layout: index, max sub-index, length, min, max, attributes
`define PAFC_ENT_W         96
`define PAFC_ENT_IDX_HI    95
`define PAFC_ENT_IDX_LO    80
`define PAFC_ENT_SUB_HI    79
`define PAFC_ENT_SUB_LO    72
`define PAFC_ENT_LEN_HI    71
`define PAFC_ENT_LEN_LO    68
`define PAFC_ENT_MIN_HI    67
`define PAFC_ENT_MIN_LO    36
`define PAFC_ENT_MAX_HI    35
`define PAFC_ENT_MAX_LO    4
`define PAFC_ENT_ATTR_HI   3
`define PAFC_ENT_ATTR_LO   0

`endif

// file: rtl/pafc_dict.v
// object dictionary lookup: index, sub-index, size, range, attributes
`timescale 1ns/10ps
`include "pafc_consts.vh"

module pafc_dict
(
	// query
	input  wire [`PAFC_IDX_W-1:0]  q_index,
	input  wire [`PAFC_SUB_W-1:0]  q_subidx,
	// answer
	output reg                     idx_hit,
	output reg                     sub_hit,
	output reg  [`PAFC_LEN_W-1:0]  obj_len,
	output reg  [`PAFC_DATA_W-1:0] obj_min,
	output reg  [`PAFC_DATA_W-1:0] obj_max,
	output reg  [`PAFC_ATTR_W-1:0] obj_attr
);

	// ============================================================
	// table entry: index, max sub-index, length, min, max, attributes
	function [`PAFC_ENT_W-1:0] entry;
		input [`PAFC_OBJ_SEL_W-1:0] sel;
		begin
			case (sel)
				3'h0:    entry = {16'h6040, 8'h00, 4'h2, 32'h00000000, 32'h0000ffff, 4'h2};
				3'h1:    entry = {16'h6041, 8'h00, 4'h2, 32'h00000000, 32'h0000ffff, 4'h3};
				3'h2:    entry = {16'h6060, 8'h00, 4'h1, 32'h00000000, 32'h0000000a, 4'h6};
				3'h3:    entry = {16'h607a, 8'h00, 4'h4, 32'h80000000, 32'h7fffffff, 4'ha};
				3'h4:    entry = {16'h60ff, 8'h00, 4'h4, 32'hfff00000, 32'h000fffff, 4'ha};
				3'h5:    entry = {16'h6083, 8'h00, 4'h4, 32'h00000001, 32'h00ffffff, 4'h6};
				3'h6:    entry = {16'h1000, 8'h00, 4'h4, 32'h00000000, 32'hffffffff, 4'h1};
				default: entry = {16'h2001, 8'h02, 4'h2, 32'h00000000, 32'h00007fff, 4'h0};
			endcase
		end
	endfunction

	integer                  i;
	reg [`PAFC_ENT_W-1:0]    e;

	always @*
	begin
		idx_hit  = 1'b0;
		sub_hit  = 1'b0;
		obj_len  = {`PAFC_LEN_W{1'b0}};
		obj_min  = {`PAFC_DATA_W{1'b0}};
		obj_max  = {`PAFC_DATA_W{1'b0}};
		obj_attr = {`PAFC_ATTR_W{1'b0}};
		e        = {`PAFC_ENT_W{1'b0}};
		for (i = 0; i < `PAFC_N_OBJ; i = i + 1)
		begin
			e = entry(i[`PAFC_OBJ_SEL_W-1:0]);
			if (e[`PAFC_ENT_IDX_HI:`PAFC_ENT_IDX_LO] == q_index)
			begin
				idx_hit  = 1'b1;
				sub_hit  = (q_subidx <= e[`PAFC_ENT_SUB_HI:`PAFC_ENT_SUB_LO]);
				obj_len  = e[`PAFC_ENT_LEN_HI:`PAFC_ENT_LEN_LO];
				obj_min  = e[`PAFC_ENT_MIN_HI:`PAFC_ENT_MIN_LO];
				obj_max  = e[`PAFC_ENT_MAX_HI:`PAFC_ENT_MAX_LO];
				obj_attr = e[`PAFC_ENT_ATTR_HI:`PAFC_ENT_ATTR_LO];
			end
		end
	end

endmodule // pafc_dict

// file: bench/pafc_master_model.sv
// network master model: offers process-data entries and reset-node commands
`timescale 1ns/10ps
`include "pafc_consts.vh"

module pafc_master_model
(
	// clock
	input  wire                      core_clk,
	// entry and command
	output reg                       pdo_valid = 1'b0,
	output reg  [`PAFC_IDX_W-1:0]    pdo_index = 16'h0000,
	output reg  [`PAFC_SUB_W-1:0]    pdo_subidx = 8'h00,
	output reg  [`PAFC_LEN_W-1:0]    pdo_len = 4'h0,
	output reg  [`PAFC_DATA_W-1:0]   pdo_data = 32'h0,
	output reg                       nmt_reset_node = 1'b0
);
	// released fields show the inverse, not the last value
	task send(input [15:0] i, input [7:0] s, input [3:0] l, input [31:0] d);
		@(posedge core_clk);
		{pdo_valid, pdo_index, pdo_subidx, pdo_len, pdo_data} <= {1'b1, i, s, l, d};
		@(posedge core_clk);
		{pdo_valid, pdo_index, pdo_subidx, pdo_len, pdo_data} <= {1'b0, ~i, ~s, ~l, ~d};
	endtask

	task reset_node;
		@(posedge core_clk);
		nmt_reset_node <= 1'b1;
		@(posedge core_clk);
		nmt_reset_node <= 1'b0;
	endtask
endmodule // pafc_master_model

// file: bench/pafc_checker_properties.sv
// concurrent checks on the fault checker ports
`timescale 1ns/10ps
`include "pafc_consts.vh"

module pafc_checker_properties
(
	// watched ports
	input  wire        core_clk,
	input  wire        reset_n,
	input  wire        pdo_valid,
	input  wire [15:0] pdo_index,
	input  wire [7:0]  pdo_subidx,
	input  wire [3:0]  pdo_len,
	input  wire [31:0] pdo_data,
	input  wire        nmt_reset_node,
	input  wire        drive_enabled_pin,
	input  wire        obj_wr_q,
	input  wire [15:0] obj_wr_index_q,
	input  wire [31:0] obj_wr_data_q,
	input  wire        fault_active_q,
	input  wire [7:0]  fault_code_q,
	input  wire        fault_event_q
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	wire fresh = pdo_valid && !fault_active_q;
	wire m6083 = fresh && pdo_index == 16'h6083 && pdo_subidx == 8'h00;

	index_fault_a: assert property (fresh && pdo_index == 16'h9999 |=>
		fault_event_q && fault_code_q == 8'h79) else $error("index fault");
	size_fault_a: assert property (m6083 && pdo_len != 4'h4 |=>
		fault_code_q == 8'h7b) else $error("size fault");
	rdonly_drop_a: assert property (fresh && pdo_index == 16'h6041 && pdo_len == 4'h2 &&
		pdo_subidx == 8'h00 && pdo_data[31:16] == 16'h0000 |=>
		fault_code_q == 8'h7d && !obj_wr_q) else $error("read-only fault");
	servo_lock_a: assert property (m6083 && pdo_len == 4'h4 && pdo_data == 32'h5 &&
		drive_enabled_pin && $past(drive_enabled_pin, 2) |=> fault_code_q == 8'h7f)
		else $error("servo lock fault");
	nmt_clear_a: assert property (nmt_reset_node && !pdo_valid |=>
		!fault_active_q && fault_code_q == 8'h00) else $error("clear failed");
	fault_hold_a: assert property (fault_active_q && !nmt_reset_node && !pdo_valid |=>
		fault_active_q && $stable(fault_code_q)) else $error("fault not held");
	wr_fields_a: assert property (obj_wr_q |-> !fault_event_q &&
		obj_wr_index_q == $past(pdo_index) && obj_wr_data_q == $past(pdo_data))
		else $error("write fields");
	one_answer_a: assert property (fresh |=> obj_wr_q != fault_event_q)
		else $error("not one answer");
endmodule // pafc_checker_properties

bind pafc_checker pafc_checker_properties chk_u (.core_clk(core_clk), .reset_n(reset_n),
	.pdo_valid(pdo_valid), .pdo_index(pdo_index), .pdo_subidx(pdo_subidx),
	.pdo_len(pdo_len), .pdo_data(pdo_data), .nmt_reset_node(nmt_reset_node),
	.drive_enabled_pin(drive_enabled_pin), .obj_wr_q(obj_wr_q),
	.obj_wr_index_q(obj_wr_index_q), .obj_wr_data_q(obj_wr_data_q),
	.fault_active_q(fault_active_q), .fault_code_q(fault_code_q),
	.fault_event_q(fault_event_q));

// file: bench/test_pafc_checker.sv
// self-checking bench for the process-data access fault checker
`timescale 1ns/10ps
`include "pafc_consts.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; \
$display("[FAIL] %0t got %h exp %h", $time, g, e); end end

module test_pafc_checker;
	reg          core_clk = 1'b0;
	reg          reset_n = 1'b0;
	reg          drv_en = 1'b0;
	wire         pdo_valid;
	wire [15:0]  pdo_index;
	wire [7:0]   pdo_subidx;
	wire [3:0]   pdo_len;
	wire [31:0]  pdo_data;
	wire         nmt_reset_node;
	wire         obj_wr_q;
	wire [15:0]  obj_wr_index_q;
	wire [7:0]   obj_wr_subidx_q;
	wire [31:0]  obj_wr_data_q;
	wire         fault_active_q;
	wire [7:0]   fault_code_q;
	wire         fault_event_q;
	int          failures = 0;
	int          total_checks = 0;
	int          cycles = 0;
	logic [65:0] notes [$];
	logic [65:0] n;
	logic [65:0] got;
	logic [55:0] tbl [0:9];
	logic [7:0]  lfsr = 8'h3a;
	logic [31:0] d;

	always #25 core_clk = ~core_clk;

	pafc_master_model m_u (.core_clk(core_clk), .pdo_valid(pdo_valid), .pdo_index(pdo_index),
		.pdo_subidx(pdo_subidx), .pdo_len(pdo_len), .pdo_data(pdo_data),
		.nmt_reset_node(nmt_reset_node));
	pafc_checker dut_u (.core_clk(core_clk), .reset_n(reset_n), .pdo_valid(pdo_valid),
		.pdo_index(pdo_index), .pdo_subidx(pdo_subidx), .pdo_len(pdo_len),
		.pdo_data(pdo_data), .nmt_reset_node(nmt_reset_node), .drive_enabled_pin(drv_en),
		.obj_wr_q(obj_wr_q), .obj_wr_index_q(obj_wr_index_q), .obj_wr_subidx_q(obj_wr_subidx_q),
		.obj_wr_data_q(obj_wr_data_q), .fault_active_q(fault_active_q),
		.fault_code_q(fault_code_q), .fault_event_q(fault_event_q));

	function logic [7:0] nxt(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction

	task complete_run;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// oldest note against each result
	always @(negedge core_clk)
	begin
		cycles++;
		if ((obj_wr_q | fault_event_q) === 1'b1)
		begin
			n = (notes.size() == 0) ? {66{1'b1}} : notes.pop_front();
			got = {obj_wr_q, fault_active_q, fault_code_q, 56'h0};
			if (obj_wr_q)
				got[55:0] = {obj_wr_index_q, obj_wr_subidx_q, obj_wr_data_q};
			`CHK(got, n)
		end
		if (cycles == 3000)
		begin
			failures++;
			complete_run();
		end
	end

	initial
	begin
		// index, sub, len, enable, data, code
		tbl = '{56'h9999_00_4_0_0005_79, 56'h2001_03_2_0_0000_7a, 56'h2001_03_4_0_0000_7a,
			56'h6083_00_2_0_0005_7b, 56'h6041_00_1_0_0000_7b, 56'h6060_00_1_0_000b_7c,
			56'h6041_00_2_0_0000_7d, 56'h1000_00_4_0_0000_7d, 56'h2001_01_2_0_0005_7e,
			56'h6083_00_4_1_0005_7f};
		repeat (12) @(posedge core_clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 10; i++)
		begin
			@(posedge core_clk);
			drv_en <= tbl[i][24];
			repeat (3) @(posedge core_clk);
			notes.push_back({2'b01, tbl[i][7:0], 56'h0});
			m_u.send(tbl[i][55:40], tbl[i][39:32], tbl[i][31:28], {16'h0, tbl[i][23:8]});
			m_u.send(16'h9999, 8'h00, 4'h4, 32'h5);
			if (i % 2)
				m_u.reset_node();
			else
			begin
				notes.push_back({2'b10, 8'h00, 16'h6040, 8'h00, 32'h0});
				m_u.send(16'h6040, 8'h00, 4'h2, 32'h0);
			end
			@(negedge core_clk);
			`CHK({fault_active_q, fault_code_q}, 9'h000)
		end
		@(posedge core_clk);
		drv_en <= 1'b0;
		repeat (3) @(posedge core_clk);
		for (int k = 0; k < 8; k++)
		begin
			lfsr = nxt(lfsr);
			d = {8'h00, lfsr, ~lfsr, lfsr};
			notes.push_back({2'b10, 8'h00, 16'h6083, 8'h00, d});
			m_u.send(16'h6083, 8'h00, 4'h4, d);
		end
		repeat (2) @(negedge core_clk);
		`CHK(notes.size(), 0)
		complete_run();
	end
endmodule // test_pafc_checker
